// ==== rtl/gated_serial_in_shift8.sv ====
// Eight-stage shift chain with AND-gated serial entry and async clear,
// plus a word FIFO collecting every eighth shifted pattern while it has room.
// Assumes serial inputs are synchronous to mclk; one clock domain.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Word FIFO between the framing logic and the consumer.
// Storage is a flop array addressed by wrapping write and read indexes.
// A push is taken only while in_ready stood high before the edge, so a
// push and a pop in the same cycle on a full FIFO still refuse the push.
// This keeps the ready flag a pure flop at the cost of one lost slot of
// throughput at the full boundary.
// The head word is registered too, so out_data is always a flop output
// and follows the read index at the same edge that takes each pop.
// Reset is synchronous: the FIFO empties and in_ready rises at the edge
// where rstn is sampled low.
// The count is one bit wider than the indexes so that full and empty
// are told apart without a spare slot.
// WIDTH and DEPTH may be changed; a depth of one still gets a one-bit
// index so that no zero-width vector is declared.
module word_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = shift8_pkg::FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [PW:0]                 count;
        logic                        ready;
        logic                        valid;
        logic [WIDTH-1:0]            head;
    } fifo_state_type;

    fifo_state_type s_q;
    fifo_state_type s_d;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : bump

    logic push;
    logic pop;
    assign push = in_valid && s_q.ready;
    assign pop  = out_ready && s_q.valid;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = bump(s_q.wr);
        end
        if (pop) begin
            s_d.rd = bump(s_q.rd);
        end
        if (push && !pop) begin
            s_d.count = s_q.count + (PW+1)'(1);
        end else if (pop && !push) begin
            s_d.count = s_q.count - (PW+1)'(1);
        end
        // Flags and head are registered so the top sees pure flop outputs
        s_d.ready = (s_d.count != (PW+1)'(DEPTH));
        s_d.valid = (s_d.count != '0);
        s_d.head  = s_d.mem[s_d.rd];
        if (!rstn) begin
            s_d       = '0;
            s_d.ready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    assign in_ready  = s_q.ready;
    assign out_valid = s_q.valid;
    assign out_data  = s_q.head;
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////
// Serial-in, parallel-out chain. Stage 0 is the first stage and takes
// the gated entry bit; stage 7 is the last and drops out of the chain.
// The framing counter and the word FIFO sit beside the chain and never
// hold it back; an async clear restarts framing but leaves the FIFO.
// rstn is synchronous and clears chain, counter and FIFO together.
module gated_serial_in_shift8 #(
    parameter int unsigned FIFO_DEPTH = shift8_pkg::FIFO_DEPTH
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       async_clear_n,
    input  wire logic       serial_in_a,
    input  wire logic       serial_in_b,
    output logic      [7:0] stage_out,
    output logic            word_valid,
    input  wire logic       word_ready,
    output logic      [7:0] word_data,
    output logic            fill_ready
);
    typedef struct packed {
        logic [7:0]                        stage;
        logic [shift8_pkg::CNT_W-1:0]      count;
    } chain_state_type;

    chain_state_type c_q;
    chain_state_type c_d;
    logic            word_push;
    logic            entry_bit;
    logic      [7:0] word_next;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // AND gate: either input low forces zero into the first stage
    function automatic logic gate_entry(
        input logic a,
        input logic b
    );
        gate_entry = a & b;
    endfunction : gate_entry

    // One-position move toward the last stage, new bit into stage 0
    function automatic logic [7:0] shift_once(
        input logic [7:0] s,
        input logic       bit_in
    );
        shift_once = {s[6:0], bit_in};
    endfunction : shift_once

    // Framing counter wraps after the eighth shift of a word
    function automatic logic [shift8_pkg::CNT_W-1:0] next_count(
        input logic [shift8_pkg::CNT_W-1:0] c
    );
        if (c == shift8_pkg::CNT_LAST) begin
            next_count = '0;
        end else begin
            next_count = c + shift8_pkg::CNT_W'(1);
        end
    endfunction : next_count

    // High in the cycle whose closing edge shifts in a word's last bit
    function automatic logic word_edge(
        input logic [shift8_pkg::CNT_W-1:0] c
    );
        word_edge = (c == shift8_pkg::CNT_LAST);
    endfunction : word_edge

    ////////////////////////////////////////////////////////////////////////
    // Chain

    assign entry_bit = gate_entry(serial_in_a, serial_in_b);

    always_comb begin
        c_d       = c_q;
        c_d.stage = shift_once(c_q.stage, entry_bit);
        c_d.count = next_count(c_q.count);
        if (!rstn) begin
            c_d.stage = shift8_pkg::STAGE_RESET;
            c_d.count = '0;
        end
    end

    // Clear is asynchronous so stage outputs drop without waiting for mclk;
    // the word counter restarts with it to keep byte framing aligned.
    always_ff @(posedge mclk or negedge async_clear_n) begin
        if (!async_clear_n) begin
            c_q.stage <= shift8_pkg::STAGE_RESET;
            c_q.count <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // A full window of eight fresh bits is offered to the FIFO; a full
    // FIFO drops it, since the chain itself never stalls.
    ////////////////////////////////////////////////////////////////////////
    // Framing into the FIFO

    assign word_push = rstn && async_clear_n && word_edge(c_q.count);
    assign word_next = c_d.stage;

    word_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (word_push),
        .in_ready  (fill_ready),
        .in_data   (word_next),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Parallel outputs

    assign stage_out = c_q.stage;
endmodule : gated_serial_in_shift8

`default_nettype wire

// ==== rtl/shift8_pkg.sv ====
// Shared constants for the gated serial-in, parallel-out shift register.
// Assumes every user writes package::name; nothing is imported.
package shift8_pkg;
    localparam int unsigned STAGES       = 8;
    localparam int unsigned FIFO_DEPTH   = 8;
    localparam int unsigned CNT_W        = $clog2(STAGES);
    localparam logic [7:0]  STAGE_RESET  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STAGES - 1);
endpackage : shift8_pkg

// ==== bench/shift8_chk.sv ====
// Checker: shift chain relations at the top ports.
// Bound into the design top; one clock, async clear.
`timescale 1ns/1ns
`default_nettype none
module shift8_chk (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       async_clear_n,
    input wire logic       serial_in_a,
    input wire logic       serial_in_b,
    input wire logic [7:0] stage_out
);
    wire        run = rstn && async_clear_n;
    wire        ab  = serial_in_a && serial_in_b;
    logic [7:0] mid_q;
    // Falling-edge copy; any change before the rise is caught
    always_ff @(negedge mclk) mid_q <= stage_out;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_run; run [*8]; endsequence
    sequence s_zero; (run && !ab) [*8]; endsequence
    sequence s_one; (run && ab) [*8]; endsequence
    chk_first_gate: assert property (
        $past(run) && run |-> stage_out[0] == $past(ab)) else $error("gate");
    chk_shift_one: assert property (
        $past(run) && run |-> stage_out[7:1] == $past(stage_out[6:0]))
        else $error("shift");
    chk_clear_zero: assert property (
        !async_clear_n |-> stage_out == 8'h00) else $error("clear");
    chk_clear_exit: assert property (
        $rose(async_clear_n) |-> stage_out == 8'h00) else $error("exit");
    chk_hold_fall: assert property (
        run |-> stage_out == mid_q) else $error("hold");
    chk_zero_fill: assert property (
        s_zero |=> stage_out == 8'h00) else $error("zeros");
    chk_ones_fill: assert property (
        s_one |=> !async_clear_n || stage_out == 8'hFF) else $error("ones");
    chk_out_last: assert property (
        s_run |=> !async_clear_n || stage_out[7] == $past(ab, 8))
        else $error("last");
endmodule : shift8_chk
bind gated_serial_in_shift8 shift8_chk u_chk (.mclk, .rstn, .async_clear_n,
    .serial_in_a, .serial_in_b, .stage_out);
`default_nettype wire

// ==== bench/serial_src.sv ====
// Partner: drives the serial inputs and consumes words.
// Outputs move 1 ns after each rising mclk edge.
`timescale 1ns/1ns
`default_nettype none
module serial_src (
    input  wire logic mclk,
    input  wire logic ones,
    input  wire logic stall,
    output logic      serial_in_a,
    output logic      serial_in_b,
    output logic      word_ready
);
    int seed = 32'h7DB7;
    initial {serial_in_a, serial_in_b, word_ready} = 3'h1;
    // Pins move 1 ns after each rise, clear of the sampling edge
    always @(posedge mclk) begin
        {serial_in_a, serial_in_b} <= #1 ones ? 2'h3 : 2'($random(seed));
        word_ready <= #1 !stall && (($random(seed) & 32'h3) != 0);
    end
endmodule : serial_src
`default_nettype wire

// ==== bench/gated_serial_in_shift8_test.sv ====
// Testbench: random traffic, an all-ones run, a clear pulse.
// Expected chain noted at each rise, compared at each fall.
`timescale 1ns/1ns
`default_nettype none
module gated_serial_in_shift8_test;
    logic mclk = 0, rstn = 0, async_clear_n = 1, ones = 0, stall = 0;
    logic serial_in_a, serial_in_b, word_valid, word_ready, fill_ready;
    logic [7:0] stage_out, word_data, exp_s, sq[$], wq[$], keep_m;
    logic exp_f, exp_v;
    int fail_count = 0, check_count = 0, n = 0;
    bit pend = 0;
    always #10 mclk = ~mclk;
    assign keep_m = {8{async_clear_n}};
    gated_serial_in_shift8 DUT (.mclk, .rstn, .async_clear_n, .serial_in_a,
        .serial_in_b, .stage_out, .word_valid, .word_ready, .word_data,
        .fill_ready);
    serial_src src (.mclk, .ones, .stall, .serial_in_a, .serial_in_b,
        .word_ready);
    task check(string nm, logic [7:0] e, logic [7:0] s);
        check_count++;
        if (s !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, s);
            fail_count++;
        end
    endtask : check
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge mclk) begin
        if (!rstn) wq.delete();
        if (!rstn || !async_clear_n) {exp_s, n} = 0;
        else begin
            exp_s = {exp_s[6:0], serial_in_a & serial_in_b};
            n++;
            // A word offered while the FIFO is full is dropped
            if (n % 8 == 0 && wq.size() + pend < shift8_pkg::FIFO_DEPTH)
                wq.push_back(exp_s);
        end
        pend = 0;
        sq.push_back(exp_s);
    end
    // Clear wins at once, so a pending note reads as zero
    always @(negedge mclk) begin
        check("stage", sq.pop_front() & keep_m, stage_out);
        exp_f = (wq.size() != shift8_pkg::FIFO_DEPTH);
        exp_v = (wq.size() != 0);
        check("fill", {7'h00, exp_f}, {7'h00, fill_ready});
        check("valid", {7'h00, exp_v}, {7'h00, word_valid});
        if (word_valid === 1'b1 && word_ready === 1'b1) begin
            check("word", wq.pop_front(), word_data);
            pend = 1;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 rstn = 1;
        repeat (300) @(posedge mclk);
        #1 stall = 1;
        repeat (90) @(posedge mclk);
        #1 stall = 0;
        repeat (40) @(posedge mclk);
        #1 ones = 1;
        repeat (10) @(posedge mclk);
        #1 async_clear_n = 0;
        #1 check("clear", 8'h00, stage_out);
        repeat (2) @(posedge mclk);
        #1 async_clear_n = 1;
        ones = 0;
        repeat (100) @(posedge mclk);
        end_sim();
    end
endmodule : gated_serial_in_shift8_test
`default_nettype wire
